// File: rtl/clf_filter.sv
`timescale 1ns/100ps
`default_nettype none
module clf_filter #(
  parameter int CNT_W = 10
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             enable,
  input  wire logic             event_in,
  input  wire logic [CNT_W-1:0] hold_cycles,
  output logic                  detect
);
  // ****************************************
  // Continuous-hold filter
  // ****************************************
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             detect;
  } clf_filt_st_t;

  clf_filt_st_t state_reg;
  clf_filt_st_t state_next;

  always_comb begin
    state_next = state_reg;
    if (!event_in) begin
      state_next.count  = '0;
      state_next.detect = 1'b0;
    end else if (state_reg.count >= hold_cycles) begin
      state_next.detect = 1'b1;
    end else begin
      state_next.count = state_reg.count + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '0;
    end else if (enable) begin
      state_reg <= state_next;
    end
  end

  assign detect = state_reg.detect;

  property p_filt_drop;
    @(posedge clock) disable iff (!rstn) (enable && !event_in) |=> !detect;
  endproperty
  a_filt_drop: assert property (p_filt_drop) else $error("filter held through drop");
endmodule // clf_filter
`default_nettype wire

// File: rtl/clf_lock_response.sv
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module clf_lock_response #(
  parameter int RETRY_DELAY_CYC = clf_pkg::RETRY_DELAY_CYC,
  parameter int CNT_W           = 10
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        enable,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [31:0] rdata,
  input  wire logic        current_limit_event,
  output logic             fault_indicator_pin_n,
  output logic      [1:0]  bridge_state,
  output logic      [10:0] no_motor_current_threshold_ma
);
  // ****************************************
  // Decode functions
  // ****************************************
  function automatic logic [10:0] thr_ma(input logic [2:0] c);
    case (c)
      3'h0, 3'h1: thr_ma = 11'd75;
      3'h2: thr_ma = 11'd100;
      3'h3: thr_ma = 11'd125;
      3'h4: thr_ma = 11'd250;
      3'h5: thr_ma = 11'd500;
      3'h6: thr_ma = 11'd750;
      default: thr_ma = 11'd1000;
    endcase
  endfunction

  function automatic logic [4:0] retry_lim(input logic [2:0] c);
    case (c)
      3'h1: retry_lim = 5'd2;
      3'h2: retry_lim = 5'd3;
      3'h3: retry_lim = 5'd5;
      3'h4: retry_lim = 5'd7;
      3'h5: retry_lim = 5'd10;
      3'h6: retry_lim = 5'd15;
      3'h7: retry_lim = 5'd20;
      default: retry_lim = 5'd0;
    endcase
  endfunction

  function automatic clf_pkg::clf_bridge_t final_bridge(input logic [3:0] m);
    case (m)
      clf_pkg::MODE_LATCH_HS, clf_pkg::MODE_RETRY_HS: final_bridge = clf_pkg::CLF_BR_HIGH_BRAKE;
      clf_pkg::MODE_LATCH_LS, clf_pkg::MODE_RETRY_LS: final_bridge = clf_pkg::CLF_BR_LOW_BRAKE;
      default: final_bridge = clf_pkg::CLF_BR_TRISTATE;
    endcase
  endfunction

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0]  sync;
    logic [31:0] setup;
    clf_pkg::clf_state_t fsm;
    clf_pkg::clf_bridge_t bridge;
    logic [4:0]  retries;
    logic [31:0] delay;
    logic [31:0] rdata;
    logic        fault;
  } clf_st_t;

  clf_st_t     state_reg;
  clf_st_t     state_next;
  logic        lock_detect;
  logic [3:0]  mode;
  logic [2:0]  filt_code;
  logic [4:0]  limit;
  logic        retry_mode;
  logic        sw_clear;

  assign mode       = state_reg.setup[clf_pkg::MODE_MSB:clf_pkg::MODE_LSB];
  assign filt_code  = state_reg.setup[clf_pkg::FILT_MSB:clf_pkg::FILT_LSB];
  assign limit      = retry_lim(state_reg.setup[clf_pkg::RETRY_MSB:clf_pkg::RETRY_LSB]);
  assign retry_mode = (mode[3:2] == 2'b01);
  assign sw_clear   = wr_stb && (addr == clf_pkg::LOCK_CONTROL_OFS)
                      && wdata[clf_pkg::CTRL_CLEAR_BIT];

  clf_filter #(
    .CNT_W       (CNT_W)
  ) u_filter (
    .clock       (clock),
    .rstn        (rstn),
    .enable      (enable),
    .event_in    (state_reg.sync[1] && !mode[3]),
    .hold_cycles (CNT_W'(filt_code * clf_pkg::CYCLES_PER_US)),
    .detect      (lock_detect)
  );

  always_comb begin
    state_next       = state_reg;
    state_next.sync  = {state_reg.sync[0], current_limit_event};
    state_next.rdata = 32'h0000_0000;
    if (wr_stb && addr == clf_pkg::FAULT_SETUP_WORD_TWO_OFS) begin
      state_next.setup = wdata;
    end
    if (rd_stb) begin
      case (addr)
        clf_pkg::FAULT_SETUP_WORD_TWO_OFS: state_next.rdata = state_reg.setup;
        clf_pkg::LOCK_STATUS_OFS: state_next.rdata = {22'h0, state_reg.retries,
                                    state_reg.fsm, state_reg.bridge, state_reg.fault};
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end
    case (state_reg.fsm)
      clf_pkg::CLF_IDLE: begin
        if (lock_detect && !mode[3]) begin
          state_next.fault  = 1'b1;
          state_next.bridge = final_bridge(mode);
          if (retry_mode && (limit == 5'd0 || state_reg.retries < limit)) begin
            state_next.fsm     = clf_pkg::CLF_RETRY_WAIT;
            state_next.retries = state_reg.retries + 5'd1;
            state_next.delay   = 32'h0000_0000;
          end else begin
            state_next.fsm = clf_pkg::CLF_LATCHED;
          end
        end
      end
      clf_pkg::CLF_RETRY_WAIT: begin
        state_next.delay = state_reg.delay + 32'h0000_0001;
        if (state_reg.delay >= 32'(RETRY_DELAY_CYC - 1)) begin
          state_next.fsm    = clf_pkg::CLF_IDLE;
          state_next.fault  = 1'b0;
          state_next.bridge = clf_pkg::CLF_BR_DRIVE;
        end
      end
      clf_pkg::CLF_LATCHED: begin
        if (sw_clear) begin
          state_next.fsm     = clf_pkg::CLF_IDLE;
          state_next.fault   = 1'b0;
          state_next.bridge  = clf_pkg::CLF_BR_DRIVE;
          state_next.retries = 5'd0;
        end
      end
      default: state_next.fsm = clf_pkg::CLF_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg       <= '0;
      state_reg.setup <= clf_pkg::FAULT_SETUP_RESET;
    end else if (enable) begin
      state_reg <= state_next;
    end
  end

  assign rdata                         = state_reg.rdata;
  assign fault_indicator_pin_n         = !state_reg.fault;
  assign bridge_state                  = state_reg.bridge;
  assign no_motor_current_threshold_ma =
    thr_ma(state_reg.setup[clf_pkg::THR_MSB:clf_pkg::THR_LSB]);

  // ****************************************
  // Checks
  // ****************************************
  property p_latch_tri;
    @(posedge clock) disable iff (!rstn)
      (enable && lock_detect && state_reg.fsm == clf_pkg::CLF_IDLE && mode[3:1] == 3'b000)
      |=> (!fault_indicator_pin_n && bridge_state == clf_pkg::CLF_BR_TRISTATE);
  endproperty
  a_latch_tri: assert property (p_latch_tri) else $error("tristate latch missed");

  property p_latch_hs;
    @(posedge clock) disable iff (!rstn)
      (enable && lock_detect && state_reg.fsm == clf_pkg::CLF_IDLE && mode == 4'h2)
      |=> (state_reg.fsm == clf_pkg::CLF_LATCHED && bridge_state == clf_pkg::CLF_BR_HIGH_BRAKE);
  endproperty
  a_latch_hs: assert property (p_latch_hs) else $error("high brake latch missed");

  property p_latch_ls;
    @(posedge clock) disable iff (!rstn)
      (enable && lock_detect && state_reg.fsm == clf_pkg::CLF_IDLE && mode == 4'h3)
      |=> (state_reg.fsm == clf_pkg::CLF_LATCHED && bridge_state == clf_pkg::CLF_BR_LOW_BRAKE);
  endproperty
  a_latch_ls: assert property (p_latch_ls) else $error("low brake latch missed");

  property p_retry_clear;
    @(posedge clock) disable iff (!rstn)
      (enable && state_reg.fsm == clf_pkg::CLF_RETRY_WAIT
       && state_reg.delay >= 32'(RETRY_DELAY_CYC - 1)) |=> fault_indicator_pin_n;
  endproperty
  a_retry_clear: assert property (p_retry_clear) else $error("retry did not clear");

  property p_limit;
    @(posedge clock) disable iff (!rstn)
      (enable && lock_detect && retry_mode && state_reg.fsm == clf_pkg::CLF_IDLE
       && limit != 5'd0 && state_reg.retries >= limit) |=> state_reg.fsm == clf_pkg::CLF_LATCHED;
  endproperty
  a_limit: assert property (p_limit) else $error("retry limit not enforced");

  property p_disabled;
    @(posedge clock) disable iff (!rstn)
      (enable && mode[3] && state_reg.fsm == clf_pkg::CLF_IDLE) [*2] |-> !lock_detect;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled mode detected lock");

  property p_disabled_idle;
    @(posedge clock) disable iff (!rstn)
      (enable && mode[3] && state_reg.fsm == clf_pkg::CLF_IDLE)
      |=> (state_reg.fsm == clf_pkg::CLF_IDLE && fault_indicator_pin_n);
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("disabled mode took action");

  property p_thr;
    @(posedge clock) disable iff (!rstn)
      (state_reg.setup[clf_pkg::THR_MSB:clf_pkg::THR_LSB] == 3'h7)
      |-> no_motor_current_threshold_ma == 11'd1000;
  endproperty
  a_thr: assert property (p_thr) else $error("threshold decode wrong");

  property p_limit_dec;
    @(posedge clock) disable iff (!rstn)
      (state_reg.setup[clf_pkg::RETRY_MSB:clf_pkg::RETRY_LSB] == 3'h5) |-> limit == 5'd10;
  endproperty
  a_limit_dec: assert property (p_limit_dec) else $error("limit decode wrong");

  property p_nodeg;
    @(posedge clock) disable iff (!rstn)
      (enable && filt_code == 3'h0 && !mode[3] && state_reg.sync[1]) [*2] |=> lock_detect;
  endproperty
  a_nodeg: assert property (p_nodeg) else $error("zero filter too slow");

  c_latch: cover property (@(posedge clock) state_reg.fsm == clf_pkg::CLF_LATCHED);
  c_retry: cover property (@(posedge clock) state_reg.fsm == clf_pkg::CLF_RETRY_WAIT);
  c_clear: cover property (@(posedge clock) sw_clear && state_reg.fsm == clf_pkg::CLF_LATCHED);
endmodule // clf_lock_response
`default_nettype wire

// File: rtl/clf_pkg.sv
// Overview of operation
// - No-motor threshold code decodes to 75,75,100,125,250,500,750,1000 mA.
// - Response codes 0 and 1 latch fault, assert indicator, tristate bridge.
// - Response code 2 latches fault, asserts indicator, brakes all high sides.
// - Response code 3 latches fault, asserts indicator, brakes all low sides.
// - Codes 4 to 7 auto-clear after retry delay; final action per code.
// - Retries beyond the limit latch fault, apply bridge state, assert indicator.
// - Codes 8 to 15 ignore current-limit events entirely.
// - Filter time code 0 means none, else that many microseconds.
// - Retry limit code decodes to unlimited,2,3,5,7,10,15,20.
`default_nettype none
package clf_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  FAULT_SETUP_WORD_TWO_OFS = 8'h00;
  localparam logic [7:0]  LOCK_STATUS_OFS          = 8'h04;
  localparam logic [7:0]  LOCK_CONTROL_OFS         = 8'h08;
  localparam logic [31:0] FAULT_SETUP_RESET        = 32'h0000_0000;
  localparam int          THR_MSB                  = 21;
  localparam int          THR_LSB                  = 19;
  localparam int          MODE_MSB                 = 18;
  localparam int          MODE_LSB                 = 15;
  localparam int          FILT_MSB                 = 14;
  localparam int          FILT_LSB                 = 12;
  localparam int          RETRY_MSB                = 2;
  localparam int          RETRY_LSB                = 0;
  localparam int          CTRL_CLEAR_BIT           = 0;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLOCK_MHZ        = 125;
  localparam int FILTER_UNIT_NS   = 1000;
  localparam int CYCLES_PER_US    = (FILTER_UNIT_NS * CLOCK_MHZ) / 1000;
  localparam int RETRY_DELAY_MS   = 100;
  localparam int RETRY_DELAY_CYC  = RETRY_DELAY_MS * CLOCK_MHZ * 1000;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {CLF_BR_DRIVE, CLF_BR_TRISTATE, CLF_BR_HIGH_BRAKE, CLF_BR_LOW_BRAKE}
    clf_bridge_t;
  typedef enum logic [1:0] {CLF_IDLE, CLF_RETRY_WAIT, CLF_LATCHED} clf_state_t;
  localparam logic [3:0] MODE_LATCH_TRI0 = 4'h0;
  localparam logic [3:0] MODE_LATCH_TRI1 = 4'h1;
  localparam logic [3:0] MODE_LATCH_HS   = 4'h2;
  localparam logic [3:0] MODE_LATCH_LS   = 4'h3;
  localparam logic [3:0] MODE_RETRY_TRI0 = 4'h4;
  localparam logic [3:0] MODE_RETRY_TRI1 = 4'h5;
  localparam logic [3:0] MODE_RETRY_HS   = 4'h6;
  localparam logic [3:0] MODE_RETRY_LS   = 4'h7;
endpackage
`default_nettype wire

// File: sim/clf_comparator_model.sv
`timescale 1ns/100ps
`default_nettype none
module clf_comparator_model (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        start,
  input  wire logic [15:0] hold_len,
  output logic             current_limit_event
);
  logic [15:0] left_reg;
  // ****************************************
  // Over-current level held for hold_len cycles
  // ****************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      left_reg <= 16'h0000;
    end else if (start) begin
      left_reg <= hold_len;
    end else if (left_reg != 16'h0000) begin
      left_reg <= left_reg - 16'h0001;
    end
  end
  assign current_limit_event = (left_reg != 16'h0000);
endmodule // clf_comparator_model
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %0h want %0h", $time, (a), (b)); end end
module testbench;
  logic clock, rstn, enable, wr_stb, rd_stb, start, fault_n;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d;
  logic [15:0] hold_len;
  logic [1:0]  bridge;
  logic [10:0] thr;
  logic        ev;
  int          errors, num_checks, f, lim, falls, run;
  clf_lock_response #(.RETRY_DELAY_CYC(20)) u_clf_lock_response (.clock(clock), .rstn(rstn),
    .enable(enable), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .current_limit_event(ev), .fault_indicator_pin_n(fault_n),
    .bridge_state(bridge), .no_motor_current_threshold_ma(thr));
  clf_comparator_model u_clf_comparator_model (.clock(clock), .rstn(rstn), .start(start),
    .hold_len(hold_len), .current_limit_event(ev));
  // ****************************************
  // Expectations and bus tasks
  // ****************************************
  function automatic logic [31:0] cfg(input int t, input int m, input int fl, input int l);
    return {10'h000, t[2:0], m[3:0], fl[2:0], 9'h000, l[2:0]};
  endfunction
  function automatic logic [10:0] exp_thr(input int c);
    logic [10:0] tab [8] = '{11'd75, 11'd75, 11'd100, 11'd125, 11'd250, 11'd500, 11'd750,
                            11'd1000};
    return tab[c];
  endfunction
  function automatic int exp_lim(input int c);
    int tab [8] = '{0, 2, 3, 5, 7, 10, 15, 20};
    return tab[c];
  endfunction
  function automatic logic [1:0] exp_br(input int m);
    return (m % 4 < 2) ? 2'h1 : m[1:0];
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    addr <= a; wdata <= v; wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    addr <= a; rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic pulse(input int n);
    @(posedge clock);
    hold_len <= n[15:0]; start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
  endtask
  task automatic wait_fault(output int n);
    for (n = 0; n < 2000 && fault_n !== 1'b0; n++) begin
      @(posedge clock); #1;
    end
    if (n >= 2000) begin
      errors++;
      test_done();
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ****************************************
  // Clock, watchdog, main sequence
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    repeat (100000) @(posedge clock);
    errors++;
    test_done();
  end
  initial begin
    {rstn, wr_stb, rd_stb, start, addr, wdata, hold_len} = '0;
    enable = 1'b1;
    errors = 0; num_checks = 0;
    f = $urandom(32'h37a2);
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    rd(8'h00, d); `CHK(d, 32'h0000_0000)
    `CHK(thr, 11'd75)
    `CHK({fault_n, bridge}, 3'h4)
    wr(8'h0C, 32'hFFFF_FFFF); rd(8'h0C, d); `CHK(d, 32'h0000_0000)
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, cfg(i, 8, 0, 0)); rd(8'h00, d);
      `CHK(thr, exp_thr(i))
      `CHK(d, cfg(i, 8, 0, 0))
    end
    $display("test threshold done");
    for (int m = 0; m < 4; m++) begin
      f = $urandom % 3;
      wr(8'h00, cfg(0, m, f, 0)); pulse(f * 125 + 20); wait_fault(run);
      repeat (60) @(posedge clock); #1;
      `CHK({fault_n, bridge}, {1'b0, exp_br(m)})
      rd(8'h04, d); `CHK(d[4:3], 2'h2)
      wr(8'h08, 32'h1); @(posedge clock); #1;
      `CHK({fault_n, bridge}, 3'h4)
    end
    $display("test latch done");
    for (int m = 8; m < 16; m++) begin
      wr(8'h00, cfg(0, m, 0, 0)); pulse(300);
      repeat (320) @(posedge clock); #1;
      `CHK(fault_n, 1'b1)
    end
    $display("test disabled done");
    f = 1 + $urandom % 3;
    wr(8'h00, cfg(0, 0, f, 0)); pulse(f * 125 - 10);
    repeat (f * 125 + 20) @(posedge clock); #1;
    `CHK(fault_n, 1'b1)
    pulse(2000); wait_fault(run);
    `CHK(run >= f * 125, 1'b1)
    `CHK(run <= f * 125 + 8, 1'b1)
    pulse(0); wr(8'h08, 32'h1);
    $display("test filter done");
    for (int m = 4; m < 8; m++) begin
      lim = 1 + $urandom % 7;
      wr(8'h00, cfg(0, m, 0, lim)); wr(8'h08, 32'h1);
      pulse(16'hFFFF); falls = 0; run = 0;
      for (int k = 0; k < 3000 && run < 60; k++) begin
        @(posedge clock); #1;
        if (fault_n === 1'b0) run++;
        else run = 0;
        if (run == 1) falls++;
      end
      if (run < 60) begin
        errors++;
        test_done();
      end
      `CHK(falls, exp_lim(lim) + 1)
      `CHK({fault_n, bridge}, {1'b0, exp_br(m)})
      pulse(0); wr(8'h08, 32'h1);
    end
    wr(8'h00, cfg(0, 4, 0, 0)); pulse(1000);
    repeat (1100) @(posedge clock);
    rd(8'h04, d); `CHK(d[4:3], 2'h0)
    `CHK(fault_n, 1'b1)
    $display("test retry done");
    test_done();
  end
endmodule // testbench
`default_nettype wire
